// File: verilog/emwls_pkg.sv
// Constants shared by the width-adaptation and lane-steering logic
package emwls_pkg;
  // Memory width codes, as presented by the chip-select configuration
  localparam logic [1:0] MW_8 = 2'h0;
  localparam logic [1:0] MW_16 = 2'h1;
  localparam logic [1:0] MW_32 = 2'h2;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORD_SEL_BIT = 1;
  // Active-low byte-lane strobe patterns
  localparam logic [3:0] BE_ALL = 4'h0;
  localparam logic [3:0] BE_LO_HALF = 4'hc;
  localparam logic [3:0] BE_HI_HALF = 4'h3;
  localparam logic [3:0] BE_BYTE0 = 4'he;
  // Follow-on address steps on the byte-granular address lines
  localparam logic [21:0] STEP_BYTE = 22'h000001;
  localparam logic [21:0] STEP_HALF = 22'h000002;
  // Last beat index per access shape
  localparam logic [1:0] LAST_ONE = 2'h0;
  localparam logic [1:0] LAST_TWO = 2'h1;
  localparam logic [1:0] LAST_FOUR = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_XFER = 4'b0100,
    ST_RESP = 4'b1000
  } emwls_state_e;
endpackage

// File: verilog/emwls_lane_map.sv
// Per-beat byte-lane strobes, write-lane placement and beat count
`timescale 1ns/100ps
module emwls_lane_map
  import emwls_pkg::*;
(
  input wire logic [1:0] width_i,
  input wire logic size32_i,
  input wire logic write_i,
  input wire logic core_i,
  input wire logic word_sel_i,
  input wire logic [1:0] beat_i,
  input wire logic [HALF_W-1:0] wdata_hi_i,
  input wire logic [HALF_W-1:0] wdata_lo_i,
  output logic [3:0] strobes_n_o,
  output logic [DATA_W-1:0] lane_data_o,
  output logic [1:0] last_beat_o
);
  always_comb begin
    strobes_n_o = BE_ALL;
    lane_data_o = '0;
    last_beat_o = LAST_ONE;
    unique case (width_i)
      MW_32: begin
        if (size32_i) begin
          // Even word on the upper lanes; only core requests may swap
          lane_data_o = (core_i && word_sel_i) ? {wdata_lo_i, wdata_hi_i}
                                               : {wdata_hi_i, wdata_lo_i};
        end else if (write_i) begin
          strobes_n_o = word_sel_i ? BE_LO_HALF : BE_HI_HALF;
          lane_data_o = word_sel_i ? {{HALF_W{1'b0}}, wdata_lo_i}
                                   : {wdata_lo_i, {HALF_W{1'b0}}};
        end
      end
      MW_16: begin
        strobes_n_o = BE_LO_HALF;
        last_beat_o = size32_i ? LAST_TWO : LAST_ONE;
        // High word goes out first, low word second
        lane_data_o = {{HALF_W{1'b0}},
                       (size32_i && beat_i == LAST_ONE) ? wdata_hi_i : wdata_lo_i};
      end
      MW_8: begin
        strobes_n_o = BE_BYTE0;
        last_beat_o = size32_i ? LAST_FOUR : LAST_TWO;
      end
      default: begin
        strobes_n_o = 4'hf;
      end
    endcase
  end
endmodule // emwls_lane_map

// File: verilog/emwls_top.sv
// Width adaptation and byte-lane steering for external data accesses
`timescale 1ns/100ps
module emwls_top
  import emwls_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] mem_width_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_size32_i,
  input wire logic req_core_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [HALF_W-1:0] req_wdata_hi_i,
  input wire logic [HALF_W-1:0] req_wdata_lo_i,
  output logic resp_valid_o,
  output logic resp_err_o,
  output logic [DATA_W-1:0] resp_rdata_o,
  output logic ext_cyc_o,
  output logic ext_we_o,
  output logic [ADDR_W-1:0] ext_addr_o,
  output logic [3:0] byte_lane_strobes_n_o,
  output logic [DATA_W-1:0] ext_data_o,
  output logic ext_data_oe_n_o,
  input wire logic [DATA_W-1:0] ext_data_i,
  input wire logic ext_ack_i
);
  emwls_state_e state_r;
  logic wr_r;
  logic sz32_r;
  logic core_r;
  logic sel_r;
  logic err_r;
  logic [1:0] width_r;
  logic [1:0] beat_r;
  logic [HALF_W-1:0] whi_r;
  logic [HALF_W-1:0] wlo_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] acc_r;
  logic cyc_r;
  logic [3:0] strobes_r;
  logic [DATA_W-1:0] wdata_r;
  logic oe_n_r;
  logic [3:0] map_strobes_n;
  logic [DATA_W-1:0] map_lane_data;
  logic [1:0] map_last_beat;
  logic take;
  logic refuse;
  logic beat_done;
  logic last_beat;

  // First address on the lines: low bits cleared below the memory's lowest line
  function automatic logic [ADDR_W-1:0] first_addr(input logic [1:0] width,
                                                   input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = addr;
    if (width == MW_32) begin
      a[1:0] = 2'h0;
    end else if (width == MW_16) begin
      a[0] = 1'b0;
    end
    return a;
  endfunction

  // Follow-on address for the next beat
  function automatic logic [ADDR_W-1:0] next_addr(input logic [1:0] width,
                                                  input logic down,
                                                  input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = addr + STEP_BYTE;
    if (width == MW_16) begin
      a = down ? addr - STEP_HALF : addr + STEP_HALF;
    end
    return a;
  endfunction

  assign req_ready_o = (state_r == ST_IDLE);
  assign take = req_valid_i && req_ready_o;
  // Writes to byte-wide memory, and unknown widths, are answered with an error
  assign refuse = (req_write_i && mem_width_i == MW_8) || (mem_width_i > MW_32);
  assign beat_done = (state_r == ST_XFER) && ext_ack_i;
  assign last_beat = (beat_r == map_last_beat);

  emwls_lane_map u_lane_map (
    .width_i(width_r),
    .size32_i(sz32_r),
    .write_i(wr_r),
    .core_i(core_r),
    .word_sel_i(sel_r),
    .beat_i(beat_r),
    .wdata_hi_i(whi_r),
    .wdata_lo_i(wlo_r),
    .strobes_n_o(map_strobes_n),
    .lane_data_o(map_lane_data),
    .last_beat_o(map_last_beat)
  );

  // Sequencer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= refuse ? ST_RESP : ST_SETUP;
          end
        end
        ST_SETUP: begin
          state_r <= ST_XFER;
        end
        ST_XFER: begin
          if (ext_ack_i) begin
            state_r <= last_beat ? ST_RESP : ST_SETUP;
          end
        end
        ST_RESP: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Request context, held for the whole access
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_r <= 1'b0;
      sz32_r <= 1'b0;
      core_r <= 1'b0;
      sel_r <= 1'b0;
      err_r <= 1'b0;
      width_r <= MW_32;
      whi_r <= '0;
      wlo_r <= '0;
    end else if (take) begin
      wr_r <= req_write_i;
      sz32_r <= req_size32_i;
      // DMA is trusted to keep the high word even, so bit 1 never swaps its words or steps its addresses down
      core_r <= req_core_i;
      sel_r <= req_addr_i[WORD_SEL_BIT];
      err_r <= refuse;
      width_r <= mem_width_i;
      whi_r <= req_wdata_hi_i;
      wlo_r <= req_wdata_lo_i;
    end
  end

  // Beat counter and address generator
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      beat_r <= LAST_ONE;
      addr_r <= '0;
    end else if (take) begin
      beat_r <= LAST_ONE;
      addr_r <= first_addr(mem_width_i, req_addr_i);
    end else if (beat_done && !last_beat) begin
      beat_r <= beat_r + 2'h1;
      addr_r <= next_addr(width_r, sz32_r && core_r && sel_r, addr_r);
    end
  end

  // Pin-side drive, loaded one cycle ahead of each strobe
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_r <= 1'b0;
      strobes_r <= 4'hf;
      wdata_r <= '0;
      oe_n_r <= 1'b1;
    end else if (state_r == ST_SETUP) begin
      cyc_r <= 1'b1;
      strobes_r <= map_strobes_n;
      wdata_r <= map_lane_data;
      oe_n_r <= !wr_r;
    end else if (beat_done) begin
      cyc_r <= 1'b0;
      strobes_r <= 4'hf;
      oe_n_r <= 1'b1;
    end
  end

  // Read assembly; narrow beats shift in so the first lands highest
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_r <= '0;
    end else if (take) begin
      acc_r <= '0;
    end else if (beat_done && !wr_r) begin
      unique case (width_r)
        MW_32: begin
          if (sz32_r) begin
            acc_r <= (core_r && sel_r) ? {ext_data_i[15:0], ext_data_i[31:16]}
                                       : ext_data_i;
          end else begin
            // Whole width was read; only the addressed word is kept
            acc_r <= {{HALF_W{1'b0}}, sel_r ? ext_data_i[15:0]
                                             : ext_data_i[31:16]};
          end
        end
        MW_16: begin
          acc_r <= {acc_r[HALF_W-1:0], ext_data_i[HALF_W-1:0]};
        end
        default: begin
          acc_r <= {acc_r[DATA_W-BYTE_W-1:0], ext_data_i[BYTE_W-1:0]};
        end
      endcase
    end
  end

  assign resp_valid_o = (state_r == ST_RESP);
  assign resp_err_o = err_r && resp_valid_o;
  assign resp_rdata_o = acc_r;
  assign ext_cyc_o = cyc_r;
  assign ext_we_o = cyc_r && wr_r;
  assign ext_addr_o = addr_r;
  assign byte_lane_strobes_n_o = strobes_r;
  assign ext_data_o = wdata_r;
  assign ext_data_oe_n_o = oe_n_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  full_strobes_a: assert property (
    ext_cyc_o && width_r == MW_32 && (sz32_r || !wr_r) |-> byte_lane_strobes_n_o == BE_ALL)
    else $error("32-bit memory access without all strobes low");

  addr_align_a: assert property (
    ext_cyc_o && width_r == MW_32 |-> ext_addr_o[1:0] == 2'h0)
    else $error("32-bit memory address not word aligned");

  word_swap_a: assert property (
    beat_done && width_r == MW_32 && sz32_r && !wr_r && core_r && sel_r
    |=> resp_valid_o && resp_rdata_o == {$past(ext_data_i[15:0]), $past(ext_data_i[31:16])})
    else $error("core word swap not applied");

  half_lanes_a: assert property (
    ext_cyc_o && width_r == MW_16 |-> byte_lane_strobes_n_o == BE_LO_HALF && !ext_addr_o[0])
    else $error("16-bit memory strobes or A1 alignment wrong");

  low_word_step_a: assert property (
    beat_done && width_r == MW_16 && sz32_r && beat_r == LAST_ONE
    |=> ext_addr_o == (core_r && sel_r ? $past(ext_addr_o) - STEP_HALF
                                       : $past(ext_addr_o) + STEP_HALF) ##2 ext_cyc_o)
    else $error("low word address or second transfer wrong");

  byte_step_a: assert property (
    beat_done && width_r == MW_8 && !last_beat |=> ext_addr_o == $past(ext_addr_o) + STEP_BYTE)
    else $error("byte address did not increment by one");

  byte_order_a: assert property (
    beat_done && width_r == MW_8 && !last_beat
    |=> acc_r[BYTE_W-1:0] == $past(ext_data_i[BYTE_W-1:0]))
    else $error("byte not shifted into result in order");

  byte_strobe_a: assert property (
    ext_cyc_o && width_r == MW_8 |-> byte_lane_strobes_n_o == BE_BYTE0)
    else $error("byte transfer strobes wrong");

  no_byte_write_a: assert property (
    take && req_write_i && mem_width_i == MW_8 |=> resp_err_o && !ext_cyc_o ##1 !ext_cyc_o)
    else $error("write to 8-bit memory not refused");

  half_write_a: assert property (
    ext_we_o && width_r == MW_32 && !sz32_r
    |-> byte_lane_strobes_n_o == (sel_r ? BE_LO_HALF : BE_HI_HALF))
    else $error("16-bit write strobe pair wrong");

  high_first_a: assert property (
    ext_we_o && width_r == MW_16 && sz32_r && beat_r == LAST_ONE
    |-> ext_data_o[HALF_W-1:0] == whi_r)
    else $error("32-bit write to 16-bit memory not high word first");

  half_read_a: assert property (
    beat_done && width_r == MW_32 && !sz32_r && !wr_r
    |=> resp_rdata_o[HALF_W-1:0] == (sel_r ? $past(ext_data_i[HALF_W-1:0])
                                           : $past(ext_data_i[DATA_W-1:HALF_W])))
    else $error("16-bit read word not picked from the full width");

  single_half_a: assert property (
    beat_done && width_r == MW_16 && !sz32_r |=> resp_valid_o)
    else $error("16-bit access of 16-bit memory took more than one transfer");

  half_result_a: assert property (
    resp_valid_o && !sz32_r |-> resp_rdata_o[DATA_W-1:HALF_W] == {HALF_W{1'b0}})
    else $error("16-bit result not on the low half of the result bus");

  no_wide_write_a: assert property (
    ext_cyc_o && width_r == MW_8 |-> !ext_we_o)
    else $error("write transfer issued to 8-bit memory");

  byte_pair_a: assert property (
    beat_done && width_r == MW_8 && !sz32_r && last_beat
    |=> resp_valid_o && resp_rdata_o[BYTE_W-1:0] == $past(ext_data_i[BYTE_W-1:0]))
    else $error("second byte of 16-bit read not in the low bits");
endmodule // emwls_top

// File: dv/emwls_mem_model.sv
// Behavioural external memory with a fixed data pattern and set ack latency
`timescale 1ns/100ps
module emwls_mem_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cyc_i,
  input wire logic [21:0] addr_i,
  input wire logic [1:0] lat_i,
  output logic ack_o,
  output logic [31:0] data_o
);
  logic [1:0] wait_r;
  // Unanswered cycles toggle the lines so stale data never looks valid
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_r <= 2'h0;
      ack_o <= 1'b0;
      data_o <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      if (cyc_i && !ack_o && wait_r == lat_i) begin
        ack_o <= 1'b1;
        data_o <= {addr_i[7:0] ^ 8'h5a, addr_i[7:0] ^ 8'h3c, addr_i[7:0] ^ 8'hc3,
                   addr_i[7:0] ^ 8'ha5};
        wait_r <= 2'h0;
      end else if (cyc_i && !ack_o) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // emwls_mem_model

// File: dv/tb_ext_mem_width_lane_steering.sv
// Self-checking bench for width adaptation and lane steering
`timescale 1ns/100ps
module tb_ext_mem_width_lane_steering;
  import emwls_pkg::*;
  typedef struct packed {
    logic [1:0] w;
    logic wr;
    logic s32;
    logic core;
    logic [21:0] a;
    logic err;
  } emwls_row_s;
  localparam logic [15:0] WHI = 16'ha1b2;
  localparam logic [15:0] WLO = 16'hc3d4;
  logic core_clk_i, reset_i, req_valid, req_ready, req_write, req_size32, req_core;
  logic resp_valid, resp_err, ext_cyc, ext_we, oe_n, ack;
  logic [1:0] mem_width, lat;
  logic [21:0] req_addr, ext_addr;
  logic [31:0] rdata, ext_dout, ext_din;
  logic [3:0] strobes;
  logic [59:0] beat_q[$];
  int fail_count, samples_checked;
  int cycles = 0;
  emwls_row_s rows[19] = '{
    '{MW_32, 1'b0, 1'b1, 1'b1, 22'h3ffff0, 1'b0},
    '{MW_32, 1'b0, 1'b1, 1'b1, 22'h000106, 1'b0},
    '{MW_32, 1'b1, 1'b1, 1'b1, 22'h000202, 1'b0},
    '{MW_32, 1'b1, 1'b1, 1'b0, 22'h000200, 1'b0},
    '{MW_32, 1'b0, 1'b0, 1'b1, 22'h00030a, 1'b0},
    '{MW_32, 1'b0, 1'b0, 1'b0, 22'h000308, 1'b0},
    '{MW_32, 1'b1, 1'b0, 1'b1, 22'h000400, 1'b0},
    '{MW_32, 1'b1, 1'b0, 1'b1, 22'h000402, 1'b0},
    '{MW_16, 1'b0, 1'b1, 1'b1, 22'h000500, 1'b0},
    '{MW_16, 1'b0, 1'b1, 1'b1, 22'h000502, 1'b0},
    '{MW_16, 1'b1, 1'b1, 1'b1, 22'h000602, 1'b0},
    '{MW_16, 1'b1, 1'b1, 1'b0, 22'h000600, 1'b0},
    '{MW_16, 1'b0, 1'b0, 1'b1, 22'h000702, 1'b0},
    '{MW_16, 1'b1, 1'b0, 1'b1, 22'h000704, 1'b0},
    '{MW_8, 1'b0, 1'b1, 1'b1, 22'h000800, 1'b0},
    '{MW_8, 1'b0, 1'b0, 1'b0, 22'h000802, 1'b0},
    '{MW_8, 1'b1, 1'b1, 1'b1, 22'h000900, 1'b1},
    '{MW_8, 1'b1, 1'b0, 1'b1, 22'h000904, 1'b1},
    '{2'h3, 1'b0, 1'b1, 1'b1, 22'h000a00, 1'b1}};

  emwls_top u_emwls_top (.core_clk_i(core_clk_i), .reset_i(reset_i), .mem_width_i(mem_width),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_write_i(req_write),
    .req_size32_i(req_size32), .req_core_i(req_core), .req_addr_i(req_addr),
    .req_wdata_hi_i(WHI), .req_wdata_lo_i(WLO), .resp_valid_o(resp_valid),
    .resp_err_o(resp_err), .resp_rdata_o(rdata), .ext_cyc_o(ext_cyc), .ext_we_o(ext_we),
    .ext_addr_o(ext_addr), .byte_lane_strobes_n_o(strobes), .ext_data_o(ext_dout),
    .ext_data_oe_n_o(oe_n), .ext_data_i(ext_din), .ext_ack_i(ack));
  emwls_mem_model u_emwls_mem_model (.clk_i(core_clk_i), .reset_i(reset_i), .cyc_i(ext_cyc),
    .addr_i(ext_addr), .lat_i(lat), .ack_o(ack), .data_o(ext_din));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Each acknowledged beat is logged with everything that qualifies it
  always @(posedge core_clk_i) begin
    cycles++;
    if (ext_cyc && ack) beat_q.push_back({ext_we, oe_n, strobes, ext_addr, ext_dout});
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic issue(input emwls_row_s r, input logic [1:0] l);
    @(posedge core_clk_i);
    {mem_width, req_write, req_size32, req_core, req_addr} <= {r.w, r.wr, r.s32, r.core, r.a};
    lat <= l;
    req_valid <= 1'b1;
    @(posedge core_clk_i);
    req_valid <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(negedge core_clk_i);
    chk(64'({req_ready, ext_cyc, strobes, oe_n, resp_valid, ext_addr}), 64'({5'h17, 3'h6, 22'h0}));
  endtask

  task automatic run_row(input emwls_row_s r, input logic [1:0] l);
    logic [21:0] ad;
    logic [31:0] d, res, wd;
    logic [59:0] got;
    logic [3:0] st;
    logic sw;
    int n;
    beat_q.delete();
    issue(r, l);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (resp_valid !== 1'b1 && n < 200);
    chk(64'({resp_valid, resp_err}), 64'({1'b1, r.err}));
    n = r.err ? 0 : (r.w == MW_8) ? (r.s32 ? 4 : 2) : (r.w == MW_16 && r.s32) ? 2 : 1;
    ad = (r.w == MW_32) ? {r.a[21:2], 2'h0} : (r.w == MW_16) ? {r.a[21:1], 1'b0} : r.a;
    sw = r.core && r.a[1];
    res = 32'h0;
    chk(64'(beat_q.size()), 64'(n));
    for (int k = 0; k < n; k++) begin
      d = {ad[7:0] ^ 8'h5a, ad[7:0] ^ 8'h3c, ad[7:0] ^ 8'hc3, ad[7:0] ^ 8'ha5};
      if (r.w == MW_32) begin
        res = !r.s32 ? {16'h0, r.a[1] ? d[15:0] : d[31:16]} : sw ? {d[15:0], d[31:16]} : d;
        wd = !r.s32 ? (r.a[1] ? {16'h0, WLO} : {WLO, 16'h0}) : sw ? {WLO, WHI} : {WHI, WLO};
        st = (r.wr && !r.s32) ? (r.a[1] ? 4'hc : 4'h3) : 4'h0;
      end else if (r.w == MW_16) begin
        res = {res[15:0], d[15:0]};
        wd = {16'h0, (r.s32 && k == 0) ? WHI : WLO};
        st = 4'hc;
      end else begin
        res = {res[23:0], d[7:0]};
        wd = 32'h0;
        st = 4'he;
      end
      got = beat_q.pop_front();
      chk(64'(got), 64'({r.wr, ~r.wr, st, ad, r.wr ? wd : got[31:0]}));
      ad = (r.w == MW_8) ? ad + 22'h1 : (sw && r.s32) ? ad - 22'h2 : ad + 22'h2;
    end
    if (!r.wr && !r.err) chk(64'(rdata), 64'(res));
  endtask

  initial begin
    {reset_i, req_valid, req_write, req_size32, req_core} = 5'h10;
    {mem_width, lat, req_addr} = 26'h0;
    fail_count = 0;
    samples_checked = 0;
    do_reset();
    foreach (rows[i]) run_row(rows[i], 2'(i));
    // Reset lands in the middle of a slow four-beat read
    issue(rows[14], 2'h3);
    repeat (5) @(posedge core_clk_i);
    do_reset();
    run_row(rows[14], 2'h1);
    final_report();
  end
endmodule // tb_ext_mem_width_lane_steering
